/* dasc_pkg.sv */
/*
 holds: constants and carrier types of the action and stack core.
 assumes: one clock; byte address is four times the index.
*/
package dasc_pkg;
    // ----------------------------------------
    // clock and timing
    // ----------------------------------------
    localparam int MCLK_MHZ = 200;
    localparam int USB_TRIG_NS = 150;
    localparam int USB_TRIG_CYC = (USB_TRIG_NS * MCLK_MHZ + 999) / 1000;

    // ----------------------------------------
    // stacks
    // ----------------------------------------
    localparam int STACK_COUNT = 8;
    localparam int USER_STACK = 0;
    localparam int SCALER_STACK = 1;

    // ----------------------------------------
    // register indices
    // ----------------------------------------
    localparam logic [3:0] REG_STATUS = 4'h0;
    localparam logic [3:0] REG_ACTION = 4'h1;
    localparam logic [3:0] REG_STK_ADDR = 4'h2;
    localparam logic [3:0] REG_STK_DATA = 4'h3;
    localparam logic [3:0] REG_STK_START0 = 4'h4;
    localparam logic [3:0] REG_LEVELS = 4'hC;

    // ----------------------------------------
    // action_control fields
    // ----------------------------------------
    localparam int ACT_MODE = 0;
    localparam int ACT_USB_TRIG = 1;
    localparam int ACT_CLEAR = 2;
    localparam int ACT_SYSRES = 3;
    localparam int ACT_SCALER = 4;
    localparam int ACT_STK_LSB = 8;
    localparam logic MODE_RST = 1'b0;
    localparam logic SYSRES_RST = 1'b0;

    // ----------------------------------------
    // status fields
    // ----------------------------------------
    localparam int ST_BUSY = 1;
    localparam int ST_STK_LSB = 2;
    localparam int ST_DUMP = 5;
    localparam int ST_SYSRES = 6;
    localparam int ST_PEND_LSB = 8;

    // ----------------------------------------
    // command header word
    // ----------------------------------------
    localparam int HDR_OP_LSB = 13;
    localparam int HDR_INT = 12;
    localparam int HDR_CFG = 9;
    localparam int HDR_WR = 8;
    localparam int WAIT_W = 12;
    localparam logic [2:0] OP_CMD = 3'h0;
    localparam logic [2:0] OP_MARK = 3'h1;
    localparam logic [2:0] OP_WAIT = 3'h2;
    localparam logic [2:0] OP_END = 3'h7;

    typedef struct packed {
        logic write;
        logic [5:0] am;
        logic [31:0] addr;
        logic [31:0] data;
        logic hasCfg;
        logic [15:0] cfg;
    } dasc_vme_req_t;

    typedef struct packed {
        logic write;
        logic [15:0] addr;
        logic [31:0] data;
    } dasc_int_req_t;
endpackage

/* dasc_action_stack_control.sv */
/*
 holds: action register, mode switch, stack trigger ordering, command list
 decoder, event FIFO, output buffer and its drain toward the USB controller.
 assumes: inputs synchronous to mclk; trigger inputs are one-cycle pulses;
 VME and internal register engines answer each request with one ack pulse.
*/
// Behaviour
// - write-only action register at index one
// - action writes accepted at any time
// - bit 0 selects autonomous mode
// - interactive mode runs host lists directly
// - autonomous mode runs stack on trigger
// - bit 1 gives 150ns trigger pulse
// - bit 2 clears internal state
// - bit 3 drives system reset in slot one
// - bit 4 requests scaler readout, first wins
// - bits 8-15 request stacks 0-7
// - scaler stack first, then ascending order
// - bit 9 acts like bit 4
// - commands run, read data into event FIFO
// - list end moves event FIFO to buffer
// - same list format from host or stack
// - internal access, marker and wait commands
// - command carries modifier, address, data, config
// - full buffer drains to USB in autonomous
// - eight stacks in 1k-word memory, programmable starts
// - stack 0 user input, 1 scaler, others irq
// - stack memory reads back unchanged
// - internal registers reached by list commands
// - header bit 12 marks internal access
`timescale 1ns/1ps
module dasc_action_stack_control
    import dasc_pkg::*;
#(
    parameter int STACK_WORDS = 1024,
    parameter int EVT_WORDS = 2048,
    parameter int OUT_WORDS = 13312
) (
    input logic mclk,
    input logic reset,
    input logic [3:0] avs_address,
    input logic avs_read,
    input logic avs_write,
    input logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input logic hostWordValid,
    input logic [15:0] hostWord,
    output logic hostWordReady,
    input logic userInputOne,
    input logic [7:0] irqStackReq,
    input logic scalerEventTrig,
    input logic scalerTimerTrig,
    input logic slotOneCtrl,
    output logic vmeReqValid,
    output dasc_vme_req_t vmeReq,
    input logic vmeAck,
    input logic [31:0] vmeRdData,
    output logic intReqValid,
    output dasc_int_req_t intReq,
    input logic intAck,
    input logic [31:0] intRdData,
    output logic usbValid,
    output logic [15:0] usbData,
    input logic usbReady,
    output logic usbTrigger,
    output logic sysResOut,
    output logic autonomousMode,
    output logic internalClear
);
    localparam int SA_W = $clog2(STACK_WORDS);
    localparam int EA_W = $clog2(EVT_WORDS);
    localparam int OA_W = $clog2(OUT_WORDS);
    localparam int EC_W = $clog2(EVT_WORDS + 1);
    localparam int OC_W = $clog2(OUT_WORDS + 1);
    localparam int TRIG_W = $clog2(USB_TRIG_CYC + 1);

    if (STACK_WORDS < 2 || (STACK_WORDS & (STACK_WORDS - 1)) != 0 || EVT_WORDS < 2
        || OUT_WORDS < 2 || OUT_WORDS > 65535) begin : g_chk
        $error("unsupported memory depth");
    end

    typedef enum logic [2:0] {
        S_IDLE, S_HDR, S_ARG, S_EXEC, S_PUSH_LO, S_PUSH_HI, S_WAIT, S_MOVE
    } dasc_seq_t;

    function automatic logic [2:0] argCount(input logic [15:0] h);
        logic [2:0] n;
        n = 3'h0;
        if (h[15:HDR_OP_LSB] == OP_MARK) begin
            n = 3'h1;
        end else if (h[15:HDR_OP_LSB] == OP_CMD && h[HDR_INT]) begin
            n = h[HDR_WR] ? 3'h3 : 3'h1;
        end else if (h[15:HDR_OP_LSB] == OP_CMD) begin
            n = 3'h2 + (h[HDR_WR] ? 3'h2 : 3'h0) + {2'h0, h[HDR_CFG]};
        end
        return n;
    endfunction

    // ----------------------------------------
    // register bus
    // ----------------------------------------
    logic busAck_r;
    logic [31:0] readData_r;
    logic [31:0] regRead;
    logic wrTake;
    logic rdTake;
    logic actWrite;
    logic [15:0] actData;

    assign avs_waitrequest = (avs_read | avs_write) & ~busAck_r;
    assign avs_readdata = readData_r;
    assign wrTake = avs_write & busAck_r;
    assign rdTake = avs_read & busAck_r;
    assign actWrite = wrTake && avs_address == REG_ACTION;
    assign actData = avs_writedata[15:0];

    always_ff @(posedge mclk) begin
        if (reset) begin
            busAck_r <= 1'b0;
        end else begin
            busAck_r <= (avs_read | avs_write) & ~busAck_r;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            readData_r <= 32'h0;
        end else if (avs_read & ~busAck_r) begin
            readData_r <= regRead;
        end
    end

    // ----------------------------------------
    // action register
    // ----------------------------------------
    logic mode_r;
    logic sysres_r;
    logic clear_r;
    logic [TRIG_W-1:0] trigCnt_r;
    logic modeNow;

    assign modeNow = actWrite ? actData[ACT_MODE] : mode_r;
    assign autonomousMode = mode_r;
    assign sysResOut = sysres_r & slotOneCtrl;
    assign usbTrigger = trigCnt_r != '0;
    assign internalClear = clear_r;

    always_ff @(posedge mclk) begin
        if (reset) begin
            mode_r <= MODE_RST;
            sysres_r <= SYSRES_RST;
        end else if (actWrite) begin
            mode_r <= actData[ACT_MODE];
            sysres_r <= actData[ACT_SYSRES];
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            trigCnt_r <= '0;
            clear_r <= 1'b0;
        end else begin
            clear_r <= actWrite & actData[ACT_CLEAR];
            if (actWrite && actData[ACT_USB_TRIG]) begin
                trigCnt_r <= TRIG_W'(USB_TRIG_CYC);
            end else if (trigCnt_r != '0) begin
                trigCnt_r <= trigCnt_r - 1'b1;
            end
        end
    end

    // ----------------------------------------
    // stack requests and ordering
    // ----------------------------------------
    logic [7:0] pending_r;
    logic [7:0] newReq;
    logic [7:0] swStk;
    logic scalerAny;
    logic [2:0] pickIdx;
    logic startAuto;
    dasc_seq_t state_r;

    assign swStk = actWrite ? actData[ACT_STK_LSB +: STACK_COUNT] : 8'h00;
    assign scalerAny = (actWrite & actData[ACT_SCALER]) | scalerEventTrig
        | scalerTimerTrig;
    assign newReq = modeNow ? (swStk | irqStackReq | (8'(scalerAny) << SCALER_STACK)
        | (8'(userInputOne) << USER_STACK)) : 8'h00;
    assign startAuto = state_r == S_IDLE && mode_r && pending_r != 8'h00 && !clear_r;

    always_comb begin
        pickIdx = 3'h0;
        for (int i = STACK_COUNT - 1; i >= 0; i--) begin
            if (pending_r[i]) begin
                pickIdx = 3'(i);
            end
        end
        if (pending_r[SCALER_STACK]) begin
            pickIdx = 3'(SCALER_STACK);
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            pending_r <= 8'h00;
        end else if (clear_r) begin
            pending_r <= newReq;
        end else begin
            pending_r <= (pending_r & ~(startAuto ? 8'h01 << pickIdx : 8'h00)) | newReq;
        end
    end

    // ----------------------------------------
    // stack memory and start addresses
    // ----------------------------------------
    logic [15:0] stkMem [STACK_WORDS];
    logic [SA_W-1:0] stkAddr_r;
    logic [SA_W-1:0] stkStart_r [STACK_COUNT];
    logic stkDataAcc;

    assign stkDataAcc = (wrTake | rdTake) && avs_address == REG_STK_DATA;

    always_ff @(posedge mclk) begin
        if (wrTake && avs_address == REG_STK_DATA) begin
            stkMem[stkAddr_r] <= avs_writedata[15:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (reset || clear_r) begin
            stkAddr_r <= '0;
        end else if (wrTake && avs_address == REG_STK_ADDR) begin
            stkAddr_r <= avs_writedata[SA_W-1:0];
        end else if (stkDataAcc) begin
            stkAddr_r <= stkAddr_r + 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            for (int i = 0; i < STACK_COUNT; i++) begin
                stkStart_r[i] <= '0;
            end
        end else if (wrTake && avs_address >= REG_STK_START0
            && avs_address < REG_STK_START0 + 4'(STACK_COUNT)) begin
            stkStart_r[3'(avs_address - REG_STK_START0)] <= avs_writedata[SA_W-1:0];
        end
    end

    // ----------------------------------------
    // list decoder
    // ----------------------------------------
    logic srcAuto_r;
    logic [SA_W-1:0] pc_r;
    logic [2:0] curStack_r;
    logic [15:0] hdr_r;
    logic [15:0] args_r [5];
    logic [2:0] argIdx_r;
    logic [2:0] argNeed_r;
    logic [WAIT_W-1:0] waitCnt_r;
    logic [31:0] rdData_r;
    logic pushPair_r;
    logic [15:0] curWord;
    logic wordOk;
    logic takeWord;
    logic isInt;
    logic execAck;
    logic evtFull;
    logic evtEmpty;
    logic outFull;
    logic evtPop;
    logic evtPush;
    logic dumping_r;

    assign curWord = srcAuto_r ? stkMem[pc_r] : hostWord;
    assign wordOk = srcAuto_r | hostWordValid;
    assign takeWord = (state_r == S_HDR || state_r == S_ARG) && wordOk;
    assign hostWordReady = !srcAuto_r && (state_r == S_HDR || state_r == S_ARG);
    assign isInt = hdr_r[HDR_INT];
    assign vmeReqValid = state_r == S_EXEC && hdr_r[15:HDR_OP_LSB] == OP_CMD && !isInt;
    assign intReqValid = state_r == S_EXEC && hdr_r[15:HDR_OP_LSB] == OP_CMD && isInt;
    assign execAck = isInt ? intAck : vmeAck;
    assign evtPush = (state_r == S_PUSH_LO || state_r == S_PUSH_HI) && !evtFull;

    always_comb begin
        vmeReq.write = hdr_r[HDR_WR];
        vmeReq.am = hdr_r[5:0];
        vmeReq.addr = {args_r[1], args_r[0]};
        vmeReq.data = hdr_r[HDR_WR] ? {args_r[3], args_r[2]} : 32'h0;
        vmeReq.hasCfg = hdr_r[HDR_CFG];
        vmeReq.cfg = !hdr_r[HDR_CFG] ? 16'h0 : hdr_r[HDR_WR] ? args_r[4] : args_r[2];
        intReq.write = hdr_r[HDR_WR];
        intReq.addr = args_r[0];
        intReq.data = {args_r[2], args_r[1]};
    end

    always_ff @(posedge mclk) begin
        if (takeWord && srcAuto_r) begin
            pc_r <= pc_r + 1'b1;
        end else if (startAuto) begin
            pc_r <= stkStart_r[pickIdx];
        end
        if (startAuto) begin
            curStack_r <= pickIdx;
        end
        if (takeWord && state_r == S_HDR) begin
            hdr_r <= curWord;
            argNeed_r <= argCount(curWord);
            waitCnt_r <= curWord[WAIT_W-1:0];
        end else if (state_r == S_WAIT && waitCnt_r != '0) begin
            waitCnt_r <= waitCnt_r - 1'b1;
        end
        if (takeWord && state_r == S_ARG) begin
            args_r[argIdx_r] <= curWord;
        end
        if (state_r == S_EXEC && hdr_r[15:HDR_OP_LSB] == OP_MARK) begin
            rdData_r <= {16'h0, args_r[0]};
        end else if (state_r == S_EXEC && execAck) begin
            rdData_r <= isInt ? intRdData : vmeRdData;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset || clear_r) begin
            state_r <= S_IDLE;
            srcAuto_r <= 1'b0;
            argIdx_r <= 3'h0;
            pushPair_r <= 1'b0;
        end else begin
            case (state_r)
                S_IDLE: begin
                    if (startAuto) begin
                        srcAuto_r <= 1'b1;
                        state_r <= S_HDR;
                    end else if (!mode_r && hostWordValid) begin
                        srcAuto_r <= 1'b0;
                        state_r <= S_HDR;
                    end
                end
                S_HDR: begin
                    argIdx_r <= 3'h0;
                    if (takeWord) begin
                        if (curWord[15:HDR_OP_LSB] == OP_END) begin
                            state_r <= S_MOVE;
                        end else if (curWord[15:HDR_OP_LSB] == OP_WAIT) begin
                            state_r <= S_WAIT;
                        end else if (argCount(curWord) != 3'h0) begin
                            state_r <= S_ARG;
                        end
                    end
                end
                S_ARG: begin
                    if (takeWord) begin
                        argIdx_r <= argIdx_r + 1'b1;
                        if (argIdx_r == argNeed_r - 1'b1) begin
                            state_r <= S_EXEC;
                        end
                    end
                end
                S_EXEC: begin
                    if (hdr_r[15:HDR_OP_LSB] == OP_MARK) begin
                        pushPair_r <= 1'b0;
                        state_r <= S_PUSH_LO;
                    end else if (execAck) begin
                        pushPair_r <= 1'b1;
                        state_r <= hdr_r[HDR_WR] ? S_HDR : S_PUSH_LO;
                    end
                end
                S_PUSH_LO: begin
                    if (!evtFull) begin
                        state_r <= pushPair_r ? S_PUSH_HI : S_HDR;
                    end
                end
                S_PUSH_HI: begin
                    if (!evtFull) begin
                        state_r <= S_HDR;
                    end
                end
                S_WAIT: begin
                    if (waitCnt_r == '0) begin
                        state_r <= S_HDR;
                    end
                end
                S_MOVE: begin
                    if (evtEmpty) begin
                        state_r <= S_IDLE;
                    end
                end
                default: begin
                    state_r <= S_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------
    // event FIFO
    // ----------------------------------------
    logic [15:0] evtMem [EVT_WORDS];
    logic [EA_W-1:0] evtWp_r;
    logic [EA_W-1:0] evtRp_r;
    logic [EC_W-1:0] evtCnt_r;

    assign evtFull = evtCnt_r == EC_W'(EVT_WORDS);
    assign evtEmpty = evtCnt_r == '0;
    assign evtPop = state_r == S_MOVE && !evtEmpty && !outFull && !dumping_r;

    always_ff @(posedge mclk) begin
        if (evtPush) begin
            evtMem[evtWp_r] <= state_r == S_PUSH_HI ? rdData_r[31:16] : rdData_r[15:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (reset || clear_r) begin
            evtWp_r <= '0;
            evtRp_r <= '0;
            evtCnt_r <= '0;
        end else begin
            if (evtPush) begin
                evtWp_r <= evtWp_r == EA_W'(EVT_WORDS - 1) ? '0 : evtWp_r + 1'b1;
            end
            if (evtPop) begin
                evtRp_r <= evtRp_r == EA_W'(EVT_WORDS - 1) ? '0 : evtRp_r + 1'b1;
            end
            if (evtPush && !evtPop) begin
                evtCnt_r <= evtCnt_r + 1'b1;
            end else if (evtPop && !evtPush) begin
                evtCnt_r <= evtCnt_r - 1'b1;
            end
        end
    end

    // ----------------------------------------
    // output buffer and drain
    // ----------------------------------------
    logic [15:0] outMem [OUT_WORDS];
    logic [OA_W-1:0] outWp_r;
    logic [OA_W-1:0] outRp_r;
    logic [OC_W-1:0] outCnt_r;
    logic outPop;
    logic dumpStart;

    assign outFull = outCnt_r == OC_W'(OUT_WORDS);
    assign usbValid = dumping_r && outCnt_r != '0;
    assign usbData = outMem[outRp_r];
    assign outPop = usbValid && usbReady;
    // interactive lists drain at list end, autonomous ones only when full
    assign dumpStart = outFull
        || (state_r == S_MOVE && evtEmpty && !srcAuto_r);

    always_ff @(posedge mclk) begin
        if (evtPop) begin
            outMem[outWp_r] <= evtMem[evtRp_r];
        end
    end

    always_ff @(posedge mclk) begin
        if (reset || clear_r) begin
            outWp_r <= '0;
            outRp_r <= '0;
            outCnt_r <= '0;
            dumping_r <= 1'b0;
        end else begin
            if (evtPop) begin
                outWp_r <= outWp_r == OA_W'(OUT_WORDS - 1) ? '0 : outWp_r + 1'b1;
            end
            if (outPop) begin
                outRp_r <= outRp_r == OA_W'(OUT_WORDS - 1) ? '0 : outRp_r + 1'b1;
            end
            if (evtPop && !outPop) begin
                outCnt_r <= outCnt_r + 1'b1;
            end else if (outPop && !evtPop) begin
                outCnt_r <= outCnt_r - 1'b1;
            end
            if (dumpStart) begin
                dumping_r <= 1'b1;
            end else if (outCnt_r == '0) begin
                dumping_r <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // register read mux
    // ----------------------------------------
    always_comb begin
        regRead = 32'h0;
        case (avs_address)
            REG_STATUS: begin
                regRead[ACT_MODE] = mode_r;
                regRead[ST_BUSY] = state_r != S_IDLE;
                regRead[ST_STK_LSB +: 3] = curStack_r;
                regRead[ST_DUMP] = dumping_r;
                regRead[ST_SYSRES] = sysres_r;
                regRead[ST_PEND_LSB +: STACK_COUNT] = pending_r;
            end
            REG_STK_ADDR: regRead = 32'(stkAddr_r);
            REG_STK_DATA: regRead = {16'h0, stkMem[stkAddr_r]};
            REG_LEVELS: regRead = {16'(outCnt_r), 16'(evtCnt_r)};
            default: begin
                if (avs_address >= REG_STK_START0
                    && avs_address < REG_STK_START0 + 4'(STACK_COUNT)) begin
                    regRead = 32'(stkStart_r[3'(avs_address - REG_STK_START0)]);
                end
            end
        endcase
    end
endmodule

/* dasc_vme_model.sv */
/* partner: VME slave; acks each request after 0 to 3 cycles
   assumes: request held until ack */
`timescale 1ns/1ps
module dasc_vme_model
    import dasc_pkg::*;
(
    input logic mclk,
    input logic reqValid,
    input dasc_vme_req_t req,
    output logic ack,
    output logic [31:0] rdData
);
    int dly;
    initial {ack, rdData} = '0;
    // idle data lines toggle
    always @(posedge mclk) begin
        ack <= 1'b0;
        rdData <= ~rdData;
        if (reqValid === 1'b1 && !ack) begin
            if (dly == 0) begin
                ack <= 1'b1;
                rdData <= {~req.addr[15:0], req.addr[15:0]};
                dly <= $urandom_range(3);
            end else begin
                dly <= dly - 1;
            end
        end
    end
endmodule

/* dasc_action_stack_control_assertions.sv */
/* checker: bus, action and handshake timing
   assumes: bound into the core, one clock */
`timescale 1ns/1ps
module dasc_chk
    import dasc_pkg::*;
(
    input logic mclk,
    input logic reset,
    input logic [3:0] avs_address,
    input logic avs_read,
    input logic avs_write,
    input logic [31:0] avs_writedata,
    input logic avs_waitrequest,
    input logic slotOneCtrl,
    input logic vmeReqValid,
    input dasc_vme_req_t vmeReq,
    input logic vmeAck,
    input logic usbValid,
    input logic [15:0] usbData,
    input logic usbReady,
    input logic usbTrigger,
    input logic sysResOut,
    input logic autonomousMode,
    input logic internalClear
);
    logic wrAct;
    assign wrAct = avs_write && !avs_waitrequest && avs_address == REG_ACTION;
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    chk_wait_first: assert property ($rose(avs_read | avs_write) |-> avs_waitrequest)
        else $error("no wait cycle");
    chk_wait_once: assert property ((avs_read | avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("wait too long");
    chk_trig_len: assert property (wrAct && avs_writedata[1] |=> usbTrigger ##29 usbTrigger ##1 !usbTrigger)
        else $error("trigger length");
    chk_clear_cause: assert property (internalClear |-> $past(wrAct && avs_writedata[2]))
        else $error("stray clear");
    chk_sysres_bit: assert property (wrAct && slotOneCtrl |=> sysResOut == $past(avs_writedata[3]))
        else $error("sysres");
    chk_mode_set: assert property (wrAct |=> autonomousMode == $past(avs_writedata[0]))
        else $error("mode");
    chk_mode_hold: assert property (!wrAct |=> $stable(autonomousMode))
        else $error("mode moved");
    chk_vme_hold: assert property (vmeReqValid && !vmeAck |=> vmeReqValid && $stable(vmeReq))
        else $error("vme dropped");
    chk_usb_hold: assert property (usbValid && !usbReady |=> usbValid && $stable(usbData))
        else $error("usb dropped");
    cover property (wrAct && avs_writedata[15:8] == 8'hFF);
    cover property (vmeAck);
    cover property (usbValid && usbReady);
endmodule
bind dasc_action_stack_control dasc_chk u_chk (.*);

/* tb_daq_action_stack_control.sv */
/* testbench: registers, lists, triggers and drain of the core
   assumes: small depths; VME partner answers every request */
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin errTotal++; \
    $display("[ERR] %0t got %h want %h", $time, a, b); end end
module tb_daq_action_stack_control;
    import dasc_pkg::*;
    logic mclk, reset, avs_read, avs_write, hostWordValid, userInputOne, scalerEventTrig;
    logic scalerTimerTrig, slotOneCtrl, usbReady, vmeReqValid, vmeAck, intReqValid, intAck;
    logic avs_waitrequest, hostWordReady, usbValid, usbTrigger, sysResOut, autonomousMode;
    logic internalClear;
    logic [3:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, vmeRdData, intRdData, q;
    logic [15:0] hostWord, usbData, w;
    logic [7:0] irqStackReq;
    logic [10:0] trg;
    assign {scalerTimerTrig, scalerEventTrig, userInputOne, irqStackReq} = trg;
    dasc_vme_req_t vmeReq;
    dasc_int_req_t intReq;
    logic [15:0] expq[$];
    int errTotal, compares, n;
    dasc_action_stack_control #(.STACK_WORDS(64), .EVT_WORDS(16), .OUT_WORDS(8)) u_dut (.*);
    dasc_vme_model u_vme (.mclk(mclk), .reqValid(vmeReqValid), .req(vmeReq), .ack(vmeAck),
        .rdData(vmeRdData));
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    task automatic results();
        $display("compares %0d mismatches %0d", compares, errTotal);
        if (errTotal == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic tmo(input bit hit);
        if (hit) begin
            errTotal++;
            $display("[ERR] %0t timeout", $time);
            results();
        end
    endtask
    // stack i/4: VME read of address i/4, then end
    function automatic logic [15:0] sw(input int i);
        logic [15:0] t[4];
        t = '{16'h0009, 16'(i / 4), 16'h0000, 16'hE000};
        return t[i % 4];
    endfunction
    task automatic run(input logic [15:0] k);
        expq.push_back(k);
        expq.push_back(~k);
    endtask
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        avs_read <= !wr;
        avs_write <= wr;
        avs_address <= a;
        avs_writedata <= d;
        n = 0;
        do begin @(posedge mclk); n++; end while (avs_waitrequest !== 1'b0 && n < 50);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        tmo(n >= 50);
    endtask
    task automatic host(input logic [15:0] d);
        @(posedge mclk);
        hostWordValid <= 1'b1;
        hostWord <= d;
        n = 0;
        do begin @(posedge mclk); n++; end while (hostWordReady !== 1'b1 && n < 50);
        hostWordValid <= 1'b0;
        tmo(n >= 50);
    endtask
    task automatic trig(input logic [10:0] v);
        @(posedge mclk);
        trg <= v;
        @(posedge mclk);
        trg <= 11'h0;
    endtask
    task automatic waitAck();
        n = 0;
        do begin @(negedge mclk); n++; end while (vmeAck !== 1'b1 && n < 100);
        tmo(n >= 100);
    endtask
    task automatic drain();
        for (n = 0; n < 2000 && expq.size() > 0; n++) begin
            @(negedge mclk);
            if ((usbValid & usbReady) === 1'b1) begin
                w = expq.pop_front();
                `CHK(usbData, w)
            end
            @(posedge mclk);
            usbReady <= 1'($urandom_range(1));
        end
        tmo(expq.size() > 0);
    endtask
    initial begin
        {avs_read, avs_write, hostWordValid, usbReady, intAck, avs_address, trg} = '0;
        {avs_writedata, hostWord, intRdData} = '0;
        slotOneCtrl = 1'b1;
        reset = 1'b1;
        n = $urandom(32'h1B2E);
        repeat (8) @(posedge mclk);
        reset <= 1'b0;
        bus(1'b1, REG_STK_ADDR, 32'h0);
        for (int i = 0; i < 32; i++) bus(1'b1, REG_STK_DATA, {16'h0, sw(i)});
        for (int k = 0; k < 8; k++) bus(1'b1, REG_STK_START0 + 4'(k), 32'(4 * k));
        bus(1'b1, REG_STK_ADDR, 32'h0);
        for (int i = 0; i < 32; i++) begin
            bus(1'b0, REG_STK_DATA, 32'h0);
            `CHK(q[15:0], sw(i))
        end
        for (int k = 0; k < 8; k++) begin
            bus(1'b0, REG_STK_START0 + 4'(k), 32'h0);
            `CHK(q[9:0], 10'(4 * k))
        end
        bus(1'b0, REG_ACTION, 32'h0);
        `CHK(q, 32'h0)
        bus(1'b0, 4'hD, 32'h0);
        `CHK(q, 32'h0)
        $display("registers done");
        bus(1'b1, REG_ACTION, 32'h000A);
        n = 0;
        repeat (40) begin @(negedge mclk); n += int'(usbTrigger === 1'b1); end
        `CHK(n, USB_TRIG_CYC)
        `CHK(sysResOut, 1'b1)
        bus(1'b1, REG_ACTION, 32'h0004);
        @(negedge mclk);
        `CHK(sysResOut, 1'b0)
        `CHK(internalClear, 1'b1)
        $display("action done");
        w = 16'($urandom);
        expq.push_back(w);
        run(16'h9);
        host(16'h2000);
        host(w);
        host(16'h4003);
        for (int i = 36; i < 40; i++) host(sw(i));
        drain();
        $display("host list done");
        run(16'h1);
        for (int k = 0; k < 8; k++) if (k != 1) run(16'(k));
        bus(1'b1, REG_ACTION, 32'hFF01);
        drain();
        `CHK(autonomousMode, 1'b1)
        $display("all stacks done");
        repeat (4) run(16'h1);
        bus(1'b1, REG_ACTION, 32'h0011);
        waitAck();
        trig(11'h200);
        waitAck();
        trig(11'h400);
        waitAck();
        bus(1'b1, REG_ACTION, 32'h0201);
        drain();
        $display("scaler done");
        run(16'h0);
        run(16'h2);
        run(16'h3);
        run(16'h7);
        trig(11'h18C);
        drain();
        $display("inputs done");
        results();
    end
endmodule
